/* lem_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the engine C map,
//          dimming input setup and output fault register group.
// Assumes: Byte-wide registers at their printed byte offsets.
// Notes:   Definitions only.
`ifndef LEM_DEFS_SVH
`define LEM_DEFS_SVH
`define LEM_ADDR_ENG_C_UP 8'h74
`define LEM_ADDR_ENG_C_LO 8'h75
`define LEM_ADDR_DIM_SETUP 8'h80
`define LEM_ADDR_FLT_UP 8'h81
`define LEM_ADDR_FLT_LO 8'h82
`define LEM_RST_ENG_C 8'h00
`define LEM_RST_DIM_SETUP 8'h04
`define LEM_RST_FLT 8'h00
`define LEM_BIT_OUT8 0
`define LEM_BIT_GLOBAL_DIM 1
`define LEM_BIT_EDGE_SEL 3
`define LEM_CLK_NS 10
`define LEM_DEV_TICK_NS 100
`define LEM_TICK_CYCLES ((`LEM_DEV_TICK_NS + `LEM_CLK_NS - 1) / `LEM_CLK_NS)
`endif

/* lem_pkg.sv */
// Purpose: Types shared by the register group and its neighbours.
// Assumes: Nothing beyond SystemVerilog packed structs and enums.
// Notes:   Field order of lem_dim_cfg_t matches the register bit order.
package lem_pkg;
   typedef struct packed {
      logic [1:0] min_pulse;
      logic [1:0] spare;
      logic edge_fall;
      logic [2:0] hyst;
   } lem_dim_cfg_t;
   typedef struct packed {
      logic engine_c_global_dim_on;
      logic [8:0] engine_c_owns_out;
   } lem_map_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lem_reg_req_t;
   typedef enum {MEAS_WAIT, MEAS_RUN} lem_meas_t;
endpackage : lem_pkg

/* lem_regs.sv */
// Purpose: Engine C output map, dimming input setup and output fault flags, with the
//          output PWM steering, minimum pulse stretcher and input period measurement.
// Assumes: Register requests arrive from the serial host controller on clk_i.
// Notes:
`timescale 1ns/100ps
`include "lem_defs.svh"
module lem_regs #(
   parameter int PERIOD_W = 20
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire lem_pkg::lem_reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_ack_o,
   input wire logic map_load_i,
   input wire lem_pkg::lem_map_t map_new_i,
   input wire logic [8:0] fault_detect_i,
   input wire logic pwm_dim_i,
   input wire logic [8:0] base_pwm_i,
   input wire logic [8:0] engine_c_pwm_i,
   input wire logic fader_c_pwm_i,
   output logic [8:0] led_pwm_o,
   output lem_pkg::lem_map_t map_o,
   output lem_pkg::lem_dim_cfg_t dim_cfg_o,
   output logic [PERIOD_W-1:0] pwm_period_o,
   output logic pwm_period_upd_o
);
   import lem_pkg::*;

   localparam int DIV_W = $clog2(`LEM_TICK_CYCLES);
   localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(`LEM_TICK_CYCLES - 1);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   function automatic logic [PERIOD_W-1:0] absdiff(input logic [PERIOD_W-1:0] a,
                                                   input logic [PERIOD_W-1:0] b);
      return (a > b) ? (a - b) : (b - a);
   endfunction : absdiff

   function automatic logic [5:0] min_cycles(input logic [1:0] code);
      return 6'((int'(code) + 1) * `LEM_TICK_CYCLES);
   endfunction : min_cycles

   // Register file.
   lem_map_t map_r, map_nxt;
   lem_dim_cfg_t cfg_r, cfg_nxt;
   logic [8:0] fault_r, fault_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic ack_r, ack_nxt;
   logic out8_fault_flag;

   assign out8_fault_flag = fault_r[8];

   always_comb begin
      map_nxt = map_r;
      cfg_nxt = cfg_r;
      rdata_nxt = rdata_r;
      if (map_load_i) begin
         map_nxt = map_new_i;
      end
      if (reg_req_i.wr && reg_req_i.addr == `LEM_ADDR_DIM_SETUP) begin
         cfg_nxt = lem_dim_cfg_t'(reg_req_i.wdata);
      end
      fault_nxt = fault_detect_i;
      ack_nxt = reg_req_i.rd;
      if (reg_req_i.rd) begin
         unique case (reg_req_i.addr)
            `LEM_ADDR_ENG_C_UP: rdata_nxt = {6'h00, map_r.engine_c_global_dim_on,
                                             map_r.engine_c_owns_out[8]};
            `LEM_ADDR_ENG_C_LO: rdata_nxt = map_r.engine_c_owns_out[7:0];
            `LEM_ADDR_DIM_SETUP: rdata_nxt = cfg_r;
            `LEM_ADDR_FLT_UP: rdata_nxt = {7'h00, out8_fault_flag};
            `LEM_ADDR_FLT_LO: rdata_nxt = fault_r[7:0];
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         map_r <= lem_map_t'(10'h000);
         cfg_r <= lem_dim_cfg_t'(`LEM_RST_DIM_SETUP);
         fault_r <= 9'h000;
         rdata_r <= 8'h00;
         ack_r <= 1'b0;
      end else begin
         map_r <= map_nxt;
         cfg_r <= cfg_nxt;
         fault_r <= fault_nxt;
         rdata_r <= rdata_nxt;
         ack_r <= ack_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign reg_ack_o = ack_r;
   assign map_o = map_r;
   assign dim_cfg_o = cfg_r;

   sequence s_read(logic [7:0] a);
      reg_req_i.rd && reg_req_i.addr == a;
   endsequence

   ro_write_ignore_a: assert property (
      reg_req_i.wr && !map_load_i |=> map_r == $past(map_r))
      else $error("Host write changed the engine C map.");
   lower_map_read_a: assert property (
      s_read(`LEM_ADDR_ENG_C_LO) |=> reg_ack_o &&
         reg_rdata_o == $past(map_r.engine_c_owns_out[7:0]))
      else $error("Lower map read returned a wrong value.");
   upper_map_read_a: assert property (
      s_read(`LEM_ADDR_ENG_C_UP) |=> reg_ack_o && reg_rdata_o[7:2] == 6'h00 &&
         reg_rdata_o[0] == $past(map_r.engine_c_owns_out[8]))
      else $error("Upper map read returned a wrong value.");
   fader_bit_read_a: assert property (
      s_read(`LEM_ADDR_ENG_C_UP) |=> reg_rdata_o[1] == $past(map_r.engine_c_global_dim_on))
      else $error("Global dimming bit read back wrong.");
   setup_write_a: assert property (
      reg_req_i.wr && reg_req_i.addr == `LEM_ADDR_DIM_SETUP |=> cfg_r == $past(reg_req_i.wdata))
      else $error("Setup register write not stored.");
   fault_upper_read_a: assert property (
      s_read(`LEM_ADDR_FLT_UP) |=> reg_rdata_o == {7'h00, $past(fault_r[8])})
      else $error("Upper fault read returned a wrong value.");
   fault_follow_a: assert property (
      ##1 fault_r == $past(fault_detect_i))
      else $error("Fault flags do not follow detection.");

   // Output steering. Global dimming gates only the outputs that engine C owns.
   logic [8:0] pwm_req;
   logic [8:0] engine_c_gated;

   assign engine_c_gated = engine_c_pwm_i &
                           {9{fader_c_pwm_i | ~map_r.engine_c_global_dim_on}};
   assign pwm_req = (map_r.engine_c_owns_out & engine_c_gated) |
                    (~map_r.engine_c_owns_out & base_pwm_i);

   map_drive_a: assert property (
      map_r.engine_c_owns_out[0] && !map_r.engine_c_global_dim_on |->
         pwm_req[0] == engine_c_pwm_i[0])
      else $error("Owned output does not follow engine C.");

   // Pulse stretcher. The minimum is latched at the rising edge, so a setup change
   // mid-pulse takes effect on the next pulse.
   logic [8:0] out_r, out_nxt;
   logic [5:0] hold_r [9];
   logic [5:0] hold_nxt [9];

   always_comb begin
      for (int n = 0; n < 9; n++) begin
         out_nxt[n] = out_r[n];
         hold_nxt[n] = hold_r[n];
         if (hold_r[n] != 6'h00) begin
            hold_nxt[n] = hold_r[n] - 6'h01;
            out_nxt[n] = 1'b1;
         end else if (pwm_req[n] && !out_r[n]) begin
            out_nxt[n] = 1'b1;
            hold_nxt[n] = min_cycles(cfg_r.min_pulse) - 6'h01;
         end else begin
            out_nxt[n] = pwm_req[n];
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_r <= 9'h000;
         for (int n = 0; n < 9; n++) begin
            hold_r[n] <= 6'h00;
         end
      end else begin
         out_r <= out_nxt;
         hold_r <= hold_nxt;
      end
   end

   assign led_pwm_o = out_r;

   logic [6:0] high_cnt_r;
   logic [5:0] min_rise_r;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         high_cnt_r <= 7'h00;
         min_rise_r <= 6'h00;
      end else begin
         if (!out_r[0]) begin
            high_cnt_r <= 7'h00;
         end else if (high_cnt_r != 7'h7f) begin
            high_cnt_r <= high_cnt_r + 7'h01;
         end
         if (out_nxt[0] && !out_r[0]) begin
            min_rise_r <= min_cycles(cfg_r.min_pulse);
         end
      end
   end

   min_pulse_len_a: assert property (
      $fell(led_pwm_o[0]) |-> high_cnt_r >= {1'b0, min_rise_r})
      else $error("Output pulse shorter than the minimum.");

   // Input period measurement. The pin passes three flops and a level counts once
   // the last two agree, which rejects a single-cycle glitch.
   logic sync1_r, sync2_r, sync3_r, lvl_r, lvl_nxt;
   logic rise, fall, sel_edge, tick;
   logic [DIV_W-1:0] div_r, div_nxt;
   logic [PERIOD_W-1:0] cnt_r, cnt_nxt, meas_r, meas_nxt;
   logic upd_r, upd_nxt;
   lem_meas_t st_r, st_nxt;

   assign rise = (sync2_r == sync3_r) && sync3_r && !lvl_r;
   assign fall = (sync2_r == sync3_r) && !sync3_r && lvl_r;
   assign sel_edge = cfg_r.edge_fall ? fall : rise;
   assign tick = (div_r == TICK_LAST);

   always_comb begin
      lvl_nxt = (sync2_r == sync3_r) ? sync3_r : lvl_r;
      div_nxt = tick ? '0 : div_r + DIV_W'(1);
      cnt_nxt = cnt_r;
      meas_nxt = meas_r;
      upd_nxt = 1'b0;
      st_nxt = st_r;
      if (tick && cnt_r != '1) begin
         cnt_nxt = cnt_r + PERIOD_W'(1);
      end
      if (sel_edge) begin
         cnt_nxt = '0;
         st_nxt = MEAS_RUN;
         if (st_r == MEAS_RUN &&
             absdiff(cnt_r, meas_r) > {{(PERIOD_W-3){1'b0}}, cfg_r.hyst}) begin
            meas_nxt = cnt_r;
            upd_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
         lvl_r <= 1'b0;
         div_r <= '0;
         cnt_r <= '0;
         meas_r <= '0;
         upd_r <= 1'b0;
         st_r <= MEAS_WAIT;
      end else begin
         sync1_r <= pwm_dim_i;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         lvl_r <= lvl_nxt;
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         meas_r <= meas_nxt;
         upd_r <= upd_nxt;
         st_r <= st_nxt;
      end
   end

   assign pwm_period_o = meas_r;
   assign pwm_period_upd_o = upd_r;

   sequence s_chosen_edge;
      (cfg_r.edge_fall ? fall : rise) && st_r == MEAS_RUN;
   endsequence

   edge_select_a: assert property (
      pwm_period_upd_o |-> $past(cfg_r.edge_fall ? fall : rise) &&
         !$past(cfg_r.edge_fall ? rise : fall))
      else $error("Period taken on the wrong edge.");
   hyst_gate_a: assert property (
      s_chosen_edge ##1 pwm_period_upd_o |->
         absdiff(pwm_period_o, $past(pwm_period_o)) > {{(PERIOD_W-3){1'b0}}, $past(cfg_r.hyst)})
      else $error("Period updated inside the hysteresis band.");
endmodule : lem_regs

/* lem_host_model.sv */
// Purpose: Host side of the register port, one byte request per call.
// Assumes: Requests are taken on the rising edge of clk_i, reads answer a cycle later.
// Notes:   Leaves one idle cycle between calls so a strobe is never driven twice at once.
`timescale 1ns/100ps
module lem_host_model (
   input wire logic clk_i,
   output lem_pkg::lem_reg_req_t req_o
);
   import lem_pkg::*;
   initial req_o = '0;
   task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      req_o = '{rd: r, wr: !r, addr: a, wdata: d};
      @(negedge clk_i);
      req_o = '0;
   endtask : xfer
endmodule : lem_host_model

/* led_engine_map_pwm_fault_regs_tb.sv */
// Purpose: Self-checking bench of the engine C map, dimming setup and fault registers.
// Assumes: Inputs change on the falling edge, read answers are matched in order.
// Notes:   Period figures allow one tick of slack for divider phase.
`timescale 1ns/100ps
`include "lem_defs.svh"
module led_engine_map_pwm_fault_regs_tb;
   import lem_pkg::*;
   logic clk_i, reset_n_i, map_load_i, pwm_dim_i, fader_c_pwm_i, reg_ack_o, pwm_period_upd_o;
   lem_reg_req_t reg_req_i;
   lem_map_t map_new_i, map_o, m;
   lem_dim_cfg_t dim_cfg_o;
   logic [8:0] fault_detect_i, base_pwm_i, engine_c_pwm_i, led_pwm_o, f, o;
   logic [7:0] reg_rdata_o, d, expq[$];
   logic [19:0] pwm_period_o;
   int fails, num_checks, upds, n, r;
   lem_regs #(.PERIOD_W(20)) uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req_i),
      .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .map_load_i(map_load_i),
      .map_new_i(map_new_i), .fault_detect_i(fault_detect_i), .pwm_dim_i(pwm_dim_i),
      .base_pwm_i(base_pwm_i), .engine_c_pwm_i(engine_c_pwm_i), .fader_c_pwm_i(fader_c_pwm_i),
      .led_pwm_o(led_pwm_o), .map_o(map_o), .dim_cfg_o(dim_cfg_o),
      .pwm_period_o(pwm_period_o), .pwm_period_upd_o(pwm_period_upd_o));
   lem_host_model host (.clk_i(clk_i), .req_o(reg_req_i));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      host.xfer(1'b1, a, 8'h00);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host.xfer(1'b0, a, v);
   endtask : wr
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   // Read answers are compared against the oldest noted expectation.
   always @(negedge clk_i) begin
      if (reg_ack_o === 1'b1) begin
         if (expq.size() == 0) begin
            fails++;
            $display("[ERR] t=%0t unexpected answer %h", $time, reg_rdata_o);
         end else begin
            chk(reg_rdata_o, expq.pop_front());
         end
      end
      if (pwm_period_upd_o === 1'b1) begin
         upds++;
      end
   end
   task automatic pw(input logic dm, input logic [8:0] e, input logic [8:0] b, input logic fd);
      @(negedge clk_i);
      map_load_i = 1'b1;
      map_new_i = {dm, o};
      engine_c_pwm_i = e;
      base_pwm_i = b;
      fader_c_pwm_i = fd;
      @(negedge clk_i);
      map_load_i = 1'b0;
      repeat (14) @(negedge clk_i);
   endtask : pw
   task automatic pin(input int per, input int cnt);
      repeat (cnt) begin
         pwm_dim_i = 1'b1;
         repeat (per / 2) @(negedge clk_i);
         pwm_dim_i = 1'b0;
         repeat (per - per / 2) @(negedge clk_i);
      end
   endtask : pin
   initial begin
      // The span below is several times the length of the whole sequence.
      #500000;
      fails++;
      tally_and_finish();
   end
   initial begin
      {map_load_i, pwm_dim_i, fader_c_pwm_i} = 3'h0;
      {map_new_i, fault_detect_i, base_pwm_i, engine_c_pwm_i} = '0;
      {fails, num_checks, upds} = '0;
      reset_n_i = 1'b0;
      r = $urandom(32'h0950);
      repeat (3) @(negedge clk_i);
      reset_n_i = 1'b1;
      rd(8'h74, 8'h00);
      rd(8'h75, 8'h00);
      rd(8'h80, 8'h04);
      rd(8'h81, 8'h00);
      rd(8'h82, 8'h00);
      rd(8'h90, 8'h00);
      $display("test reset values done");
      m = lem_map_t'(10'($urandom));
      f = 9'($urandom);
      @(negedge clk_i);
      map_load_i = 1'b1;
      map_new_i = m;
      fault_detect_i = f;
      @(negedge clk_i);
      map_load_i = 1'b0;
      chk(20'(map_o), 20'(m));
      wr(8'h74, 8'($urandom));
      wr(8'h75, ~m[7:0]);
      wr(8'h81, 8'hff);
      wr(8'h82, ~f[7:0]);
      rd(8'h74, {6'h00, m[9:8]});
      rd(8'h75, m[7:0]);
      rd(8'h81, {7'h00, f[8]});
      rd(8'h82, f[7:0]);
      $display("test map and faults done");
      o = 9'h000;
      pw(1'b0, 9'h000, 9'h000, 1'b0);
      for (int c = 0; c < 4; c++) begin
         d = {2'(c), 2'(c + 1), 1'(c), 3'(c + 2)};
         wr(8'h80, d);
         rd(8'h80, d);
         chk(20'(dim_cfg_o), 20'(d));
         base_pwm_i[0] = 1'b1;
         @(negedge clk_i);
         base_pwm_i[0] = 1'b0;
         // The output rose at the edge just passed, so this cycle already counts.
         n = (led_pwm_o[0] === 1'b1) ? 1 : 0;
         for (int w = 0; w < 100; w++) begin
            @(negedge clk_i);
            if (led_pwm_o[0] === 1'b1) begin
               n++;
            end
         end
         chk(20'(n), 20'((c + 1) * `LEM_TICK_CYCLES));
      end
      $display("test setup and minimum pulse done");
      wr(8'h80, 8'h00);
      o = 9'($urandom);
      pw(1'b1, 9'h1ff, 9'h000, 1'b1);
      chk(20'(led_pwm_o), 20'(o));
      pw(1'b1, 9'h1ff, 9'h000, 1'b0);
      chk(20'(led_pwm_o), 20'h0);
      pw(1'b0, 9'h1ff, 9'h000, 1'b0);
      chk(20'(led_pwm_o), 20'(o));
      pw(1'b0, 9'h000, 9'h1ff, 1'b1);
      chk(20'(led_pwm_o), 20'(o ^ 9'h1ff));
      $display("test output steering done");
      wr(8'h80, 8'h07);
      upds = 0;
      pin(500, 3);
      pin(530, 2);
      pin(700, 2);
      pwm_dim_i = 1'b1;
      repeat (20) @(negedge clk_i);
      chk(20'(upds), 20'd2);
      chk(20'(pwm_period_o >= 69 && pwm_period_o <= 71), 20'd1);
      $display("test period hysteresis done");
      repeat (4) @(negedge clk_i);
      chk(20'(expq.size()), 20'd0);
      tally_and_finish();
   end
endmodule : led_engine_map_pwm_fault_regs_tb
